// >>> spcs_regs.svh
// constants of the chip-select hold controller
// assumes inclusion by the shifter and the select controller by its bare name
`ifndef SPCS_REGS_SVH
`define SPCS_REGS_SVH

`define SPCS_WORD_W 8
`define SPCS_NSEL 4
`define SPCS_DLY_W 8
// each unit of the inter-transfer delay is 2**shift clock cycles
`define SPCS_DLY_SHIFT 5
`define SPCS_SEL_ALL_OFF 4'hF

`endif

// >>> spcs_pkg.sv
// types of the chip-select hold controller
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package spcs_pkg;
    typedef enum logic [2:0] {
        SPCS_ST_IDLE,
        SPCS_ST_XFER,
        SPCS_ST_DELAY,
        SPCS_ST_END,
        SPCS_ST_HOLD
    } spcs_state_t;
endpackage

`default_nettype wire

// >>> spcs_shift_if.sv
// link between the select controller and its shift register
// assumes both ends run on the same clock
`default_nettype none

interface spcs_shift_if #(parameter int WORD_W = 8);
    logic load;
    logic [WORD_W-1:0] word;
    logic sck_rise;
    logic sck_fall;
    logic miso_s;
    logic mosi;
    logic done;
    logic [WORD_W-1:0] rx_word;

    modport ctrl (output load, output word, output sck_rise, output sck_fall,
                  output miso_s, input mosi, input done, input rx_word);
    modport shifter (input load, input word, input sck_rise, input sck_fall,
                     input miso_s, output mosi, output done, output rx_word);
endinterface

`default_nettype wire

// >>> spcs_shifter.sv
// internal shift register: one word out msb first, one word in
// assumes sck edges arrive as one-cycle pulses of the local clock
`default_nettype none
`include "spcs_regs.svh"

module spcs_shifter import spcs_pkg::*; #(
    parameter int WORD_W = `SPCS_WORD_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // controller side
    spcs_shift_if.shifter sh
);
    localparam int CNT_W = $clog2(WORD_W + 1);

    logic [WORD_W-1:0] tx_sreg;
    logic [WORD_W-1:0] rx_sreg;
    logic [CNT_W-1:0] bits_left;
    logic active;
    logic done;
    logic [WORD_W-1:0] rx_word;
    logic [1:0] blank;
    logic seen_rise;

    // the synchroniser lags the pin by one to two clocks, so a rise seen in the
    // first two cycles after load happened before the select fell: ignore it
    wire rise_ok = active && sh.sck_rise && !blank[1];
    // no shift before the slave has sampled the first bit
    wire fall_ok = active && sh.sck_fall && seen_rise;
    wire last_fall = fall_ok && (bits_left == CNT_W'(1));

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            tx_sreg <= '0;
            rx_sreg <= '0;
            bits_left <= '0;
            active <= 1'b0;
            done <= 1'b0;
            rx_word <= '0;
            blank <= '0;
            seen_rise <= 1'b0;
        end
        else
        begin
            done <= last_fall;
            blank <= sh.load ? 2'h3 : {blank[0], 1'b0};
            seen_rise <= !sh.load && (seen_rise || rise_ok);
            if (sh.load)
            begin
                tx_sreg <= sh.word;
                bits_left <= CNT_W'(WORD_W);
                active <= 1'b1;
            end
            else if (fall_ok)
            begin
                tx_sreg <= {tx_sreg[WORD_W-2:0], 1'b0};
                bits_left <= bits_left - CNT_W'(1);
                active <= !last_fall;
            end
            if (rise_ok)
                rx_sreg <= {rx_sreg[WORD_W-2:0], sh.miso_s};
            if (last_fall)
                rx_word <= rx_sreg;
        end
    end

    assign sh.mosi = tx_sreg[WORD_W-1];
    assign sh.done = done;
    assign sh.rx_word = rx_word;
endmodule // spcs_shifter

`default_nettype wire

// >>> spcs_select_ctrl.sv
// chip-select hold control of an spi master, with holding register and shifter
// assumes the sck input is a free baud clock from outside this clock domain
// Function
// - holding-empty flag rises once the held word moves into the shifter.
// - next word in time for the same select keeps that select low between words.
// - select lines are active low.
// - per-select programmable delay between transfers; zero adds none.
// - each of four selects has a hold-select-after-transfer bit.
// - with hold set, selects keep their state until another select is wanted or a final command is pending.
// - with hold set, the select stays low even without a new word.
// - with hold clear, the select stays low only if the reload came in time.
// - the dma request follows the holding-empty flag; timely reload not guaranteed.
`default_nettype none
`include "spcs_regs.svh"

module spcs_select_ctrl import spcs_pkg::*; #(
    parameter int WORD_W = `SPCS_WORD_W,
    parameter int NSEL = `SPCS_NSEL,
    parameter int DLY_W = `SPCS_DLY_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // holding register feed
    input wire logic tx_wr,
    input wire logic [WORD_W-1:0] tx_data,
    input wire logic [$clog2(NSEL)-1:0] tx_sel,
    output logic tx_holding_empty_flag,
    output logic dma_tx_req,
    // configuration and commands
    input wire logic [NSEL-1:0] hold_select_after_xfer,
    input wire logic [NSEL*DLY_W-1:0] inter_xfer_delay,
    input wire logic final_xfer_cmd,
    // link pins
    input wire logic link_sck,
    input wire logic miso,
    output logic mosi,
    output logic [NSEL-1:0] periph_select_n,
    // status
    output logic xfer_busy,
    output logic final_pending,
    output logic [WORD_W-1:0] rx_word,
    output logic rx_valid
);
    localparam int SEL_W = $clog2(NSEL);
    localparam int CNT_W = DLY_W + `SPCS_DLY_SHIFT;

    if (NSEL != 4 || WORD_W < 2 || WORD_W > 32 || DLY_W < 1)
    begin : g_bad_param
        $error("spcs_select_ctrl: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and sck edge detection

    logic sck_m;
    logic sck_s;
    logic sck_d;
    logic miso_m;
    logic miso_s;

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_d <= 1'b0;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end
        else
        begin
            sck_m <= link_sck;
            sck_s <= sck_m;
            sck_d <= sck_s;
            miso_m <= miso;
            miso_s <= miso_m;
        end
    end

    spcs_shift_if #(.WORD_W(WORD_W)) sh ();

    spcs_shifter #(.WORD_W(WORD_W)) u_shifter (
        .clk(clk),
        .reset_n(reset_n),
        .sh(sh)
    );

    ////////////////////////////////////////////////////////////////////////////
    // holding register, sequencer and select state

    spcs_state_t state;
    spcs_state_t next_state;
    logic hold_full;
    logic [WORD_W-1:0] hold_word;
    logic [SEL_W-1:0] hold_sel;
    logic [SEL_W-1:0] cur_sel;
    logic [CNT_W-1:0] dly_cnt;
    logic [CNT_W-1:0] next_dly_cnt;
    logic [NSEL-1:0] next_select_n;
    logic final_pend;
    logic rx_valid_q;

    wire [DLY_W-1:0] cur_delay = inter_xfer_delay[cur_sel*DLY_W +: DLY_W];
    wire cur_hold = hold_select_after_xfer[cur_sel];
    wire same_sel = hold_full && (hold_sel == cur_sel);
    // feeder writes only while empty; a write into a full register is dropped
    wire accept_wr = tx_wr && !hold_full;
    wire in_end = (state == SPCS_ST_END);
    wire in_hold = (state == SPCS_ST_HOLD);
    // the idle state always leaves all selects high for at least one cycle
    wire load_idle = (state == SPCS_ST_IDLE) && hold_full;
    // back-to-back word on the same select keeps the select low
    wire load_chain = (in_end || in_hold) && same_sel;
    wire load_now = load_idle || load_chain;
    // a final command waits while a reloaded word still belongs to the burst
    wire consume_final = final_pend && (in_end || in_hold) && !same_sel;
    wire release_end = in_end && !same_sel && (final_pend || !cur_hold);
    // hold clear in hold state when another select is asked for or a final command is pending
    wire release_hold = in_hold && !same_sel && (final_pend || hold_full);
    wire release_sel = release_end || release_hold;
    wire [NSEL-1:0] sel_onehot = NSEL'(1) << hold_sel;

    always_comb
    begin
        next_state = state;
        next_dly_cnt = dly_cnt;
        next_select_n = periph_select_n;
        unique case (state)
            SPCS_ST_IDLE:
                if (load_idle)
                begin
                    next_state = SPCS_ST_XFER;
                    next_select_n = ~sel_onehot;
                end
            SPCS_ST_XFER:
                if (sh.done)
                begin
                    if (cur_delay == '0)
                        next_state = SPCS_ST_END;
                    else
                    begin
                        next_state = SPCS_ST_DELAY;
                        next_dly_cnt = {cur_delay, `SPCS_DLY_SHIFT'(0)};
                    end
                end
            SPCS_ST_DELAY:
            begin
                next_dly_cnt = dly_cnt - CNT_W'(1);
                if (dly_cnt == CNT_W'(1))
                    next_state = SPCS_ST_END;
            end
            SPCS_ST_END, SPCS_ST_HOLD:
                if (load_chain)
                    next_state = SPCS_ST_XFER;
                else if (release_sel)
                begin
                    next_state = SPCS_ST_IDLE;
                    next_select_n = `SPCS_SEL_ALL_OFF;
                end
                else
                    next_state = SPCS_ST_HOLD;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= SPCS_ST_IDLE;
            dly_cnt <= '0;
            periph_select_n <= `SPCS_SEL_ALL_OFF;
            cur_sel <= '0;
        end
        else
        begin
            state <= next_state;
            dly_cnt <= next_dly_cnt;
            periph_select_n <= next_select_n;
            if (load_now)
                cur_sel <= hold_sel;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            hold_full <= 1'b0;
            hold_word <= '0;
            hold_sel <= '0;
        end
        else if (accept_wr)
        begin
            hold_full <= 1'b1;
            hold_word <= tx_data;
            hold_sel <= tx_sel;
        end
        else if (load_now)
            hold_full <= 1'b0;
    end

    // a command arriving in the consuming cycle is kept
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            final_pend <= 1'b0;
        else
            final_pend <= final_xfer_cmd || (final_pend && !consume_final);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            rx_valid_q <= 1'b0;
        else
            rx_valid_q <= sh.done;
    end

    ////////////////////////////////////////////////////////////////////////////
    // connections

    assign sh.load = load_now;
    assign sh.word = hold_word;
    assign sh.sck_rise = sck_s && !sck_d;
    assign sh.sck_fall = !sck_s && sck_d;
    assign sh.miso_s = miso_s;

    assign tx_holding_empty_flag = !hold_full;
    // dma reload is paced by the same flag; it may still come too late
    assign dma_tx_req = !hold_full;
    assign mosi = sh.mosi;
    assign xfer_busy = (state != SPCS_ST_IDLE) && (state != SPCS_ST_HOLD);
    assign final_pending = final_pend;
    assign rx_word = sh.rx_word;
    assign rx_valid = rx_valid_q;
endmodule // spcs_select_ctrl

`default_nettype wire

// >>> spcs_select_ctrl_checker.sv
// port checker of the chip-select hold controller
// assumes the bind below and one clock domain on clk
`default_nettype none

module spcs_select_ctrl_checker #(
    parameter int NSEL = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // feed and command
    input wire logic tx_wr,
    input wire logic [$clog2(NSEL)-1:0] tx_sel,
    input wire logic tx_holding_empty_flag,
    input wire logic dma_tx_req,
    input wire logic final_xfer_cmd,
    // selects and status
    input wire logic [NSEL-1:0] periph_select_n,
    input wire logic xfer_busy,
    input wire logic final_pending
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_dma_follows_flag: assert property (dma_tx_req == tx_holding_empty_flag)
        else $error("dma request differs from empty flag");
    a_write_fills_holding: assert property (tx_wr && tx_holding_empty_flag |=>
        !tx_holding_empty_flag) else $error("accepted write left flag high");
    a_flag_rise_on_load: assert property ($rose(tx_holding_empty_flag) |->
        xfer_busy && periph_select_n != 4'hF) else $error("flag rose without a load");
    a_one_select_low: assert property ($onehot0(~periph_select_n))
        else $error("more than one select low");
    a_idle_load_selects: assert property (tx_wr && tx_holding_empty_flag && !xfer_busy
        && periph_select_n == 4'hF ##2 1 |-> periph_select_n == ~(4'h1 << $past(tx_sel, 2)))
        else $error("wrong select after load");
    a_no_direct_swap: assert property (periph_select_n != 4'hF |=>
        periph_select_n == 4'hF || $stable(periph_select_n)) else $error("select swapped");
    a_hold_keeps_select: assert property (periph_select_n != 4'hF && !xfer_busy
        && !final_pending && !final_xfer_cmd && !tx_wr && tx_holding_empty_flag
        |=> $stable(periph_select_n)) else $error("held select changed");
    a_final_releases: assert property (final_pending && !xfer_busy
        && tx_holding_empty_flag && periph_select_n != 4'hF |=> periph_select_n == 4'hF)
        else $error("final command did not release");
    a_final_consumed: assert property (final_pending && !xfer_busy && !final_xfer_cmd
        && tx_holding_empty_flag && periph_select_n != 4'hF |=> !final_pending)
        else $error("final command not consumed");
endmodule // spcs_select_ctrl_checker

bind spcs_select_ctrl spcs_select_ctrl_checker #(.NSEL(NSEL)) u_spcs_select_ctrl_checker (
    .clk, .reset_n, .tx_wr, .tx_sel, .tx_holding_empty_flag, .dma_tx_req,
    .final_xfer_cmd, .periph_select_n, .xfer_busy, .final_pending);

`default_nettype wire

// >>> spcs_slave_model.sv
// behavioural spi slaves behind the four select lines
// assumes a free sck and mosi moving on its falling edge
`default_nettype none

module spcs_slave_model #(
    parameter logic [7:0] ANSWER = 8'h5A
) (
    // link pins
    input wire logic link_sck,
    input wire logic [3:0] periph_select_n,
    input wire logic mosi,
    output logic miso,
    // frames and last byte seen so far
    output var int frame_count,
    output logic [7:0] mosi_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    wire all_off;
    logic [7:0] shreg = 8'h00;
    logic seen_rise = 1'b0;

    assign all_off = &periph_select_n;
    initial miso = 1'b0;
    initial frame_count = 0;
    initial mosi_byte = 8'h00;

    always @(negedge all_off)
    begin
        frame_count = frame_count + 1;
        shreg = ANSWER;
        miso = ANSWER[7];
        seen_rise = 1'b0;
    end

    // sample on rise; move on falls only once a rise was seen in the frame
    always @(posedge link_sck)
    begin
        if (!all_off)
        begin
            mosi_byte = {mosi_byte[6:0], mosi};
            seen_rise = 1'b1;
        end
    end

    // released line toggles so a stale bit never reads as data
    always @(negedge link_sck)
    begin
        if (all_off)
            miso = ~miso;
        else if (seen_rise)
        begin
            shreg = {shreg[6:0], shreg[7]};
            miso = shreg[7];
        end
    end
endmodule // spcs_slave_model

`default_nettype wire

// >>> spcs_select_ctrl_test.sv
// self-checking bench of the chip-select hold controller
// assumes the slave model and the bound checker compile alongside
`default_nettype none

module spcs_select_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic link_sck = 1'b0;
    logic tx_wr = 1'b0;
    logic final_xfer_cmd = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic [1:0] tx_sel = 2'h0;
    logic [3:0] hold_select_after_xfer = 4'h0;
    logic [31:0] inter_xfer_delay = 32'h0;
    logic miso, mosi, tx_holding_empty_flag, dma_tx_req, xfer_busy, final_pending, rx_valid;
    logic [3:0] periph_select_n;
    logic [7:0] rx_word;
    logic [7:0] mosi_byte;
    int fail_count = 0;
    int check_count = 0;
    int rx_count = 0;
    int frame_count, d0, d1, f0;

    spcs_select_ctrl u_spcs_select_ctrl (.clk, .reset_n, .tx_wr, .tx_data, .tx_sel,
        .tx_holding_empty_flag, .dma_tx_req, .hold_select_after_xfer, .inter_xfer_delay,
        .final_xfer_cmd, .link_sck, .miso, .mosi, .periph_select_n, .xfer_busy,
        .final_pending, .rx_word, .rx_valid);
    spcs_slave_model u_spcs_slave_model (.link_sck, .periph_select_n, .mosi, .miso,
        .frame_count, .mosi_byte);

    // receive pulses, read before the edge that clears them
    always @(posedge clk)
    begin
        if (rx_valid === 1'b1)
            rx_count++;
    end

    initial
    begin
        forever #5 clk = ~clk;
    end
    // odd offset keeps sck edges 2 ns after a clk rise, never on one
    initial
    begin
        #37;
        forever #80 link_sck = ~link_sck;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic give_up;
        fail_count++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
    endtask
    task automatic write_word(input logic [1:0] sel, input logic [7:0] data);
        for (int n = 0; tx_holding_empty_flag !== 1'b1; n++)
        begin
            if (n > 3000)
                give_up();
            tick();
        end
        tx_wr = 1'b1;
        tx_sel = sel;
        tx_data = data;
        tick();
        tx_wr = 1'b0;
    endtask
    // counts select-low cycles until everything is released
    task automatic wait_idle(output int low);
        low = 0;
        for (int n = 0; n < 5000; n++)
        begin
            tick();
            if (periph_select_n !== 4'hF)
                low++;
            else if (xfer_busy === 1'b0 && low > 0)
                return;
        end
        give_up();
    endtask
    task automatic wait_quiet;
        for (int n = 0; n < 3000; n++)
        begin
            tick();
            if (xfer_busy === 1'b0)
                return;
        end
        give_up();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check(periph_select_n === 4'hF, "selects after reset");
        check(tx_holding_empty_flag === 1'b1 && dma_tx_req === 1'b1, "flags after reset");
        check(xfer_busy === 1'b0 && final_pending === 1'b0, "status after reset");
    endtask
    task automatic t_single;
        write_word(2'h0, 8'hC3);
        tick();
        check(periph_select_n === 4'hE, "select 0 not low");
        check(tx_holding_empty_flag === 1'b1, "word not moved to shifter");
        wait_idle(d0);
        check(periph_select_n === 4'hF, "select 0 not released");
        check(mosi_byte === 8'hC3, "word not sent msb first");
        check(rx_word === 8'h5A && rx_count == 1, "slave answer not received");
    endtask
    task automatic t_burst;
        f0 = frame_count;
        write_word(2'h1, 8'h11);
        write_word(2'h1, 8'h22);
        tick();
        tx_wr = 1'b1;
        tx_sel = 2'h2;
        tick();
        tx_wr = 1'b0;
        write_word(2'h1, 8'h44);
        wait_idle(d1);
        check(frame_count == f0 + 1, "select rose inside burst");
    endtask
    task automatic t_hold;
        hold_select_after_xfer = 4'h4;
        f0 = frame_count;
        write_word(2'h2, 8'h5C);
        wait_quiet();
        repeat (100) tick();
        check(periph_select_n === 4'hB, "held select dropped");
        write_word(2'h2, 8'h6D);
        wait_quiet();
        check(frame_count == f0 + 1 && periph_select_n === 4'hB, "hold broke on reload");
        write_word(2'h1, 8'h7E);
        wait_idle(d1);
        check(frame_count == f0 + 2, "other select not taken");
        write_word(2'h2, 8'h8F);
        final_xfer_cmd = 1'b1;
        tick();
        final_xfer_cmd = 1'b0;
        check(final_pending === 1'b1 && periph_select_n === 4'hB, "final acted early");
        wait_idle(d1);
        check(final_pending === 1'b0, "final not consumed");
        hold_select_after_xfer = 4'h0;
    endtask
    task automatic t_delay;
        inter_xfer_delay = 32'h0100_0000;
        write_word(2'h3, 8'h96);
        tick();
        wait_idle(d1);
        check(d1 - d0 >= 16 && d1 - d0 <= 48, "inter-transfer delay");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) tick();
        reset_n = 1'b1;
        tick();
        t_reset();
        t_single();
        t_burst();
        t_hold();
        t_delay();
        complete_run();
    end
endmodule // spcs_select_ctrl_test

`default_nettype wire
